//--- core/ctm_pkg.sv
package ctm_pkg;
	// register addresses carried in the low seven bits of a command byte
	localparam logic [6:0] ADDR_CLEAR = 7'h63;
	localparam logic [6:0] ADDR_MODE = 7'h64;
	localparam logic [6:0] ADDR_CT_LOW = 7'h65;
	localparam logic [6:0] ADDR_CT_HIGH = 7'h66;
	localparam logic [6:0] ADDR_DT_LOW = 7'h67;
	localparam logic [6:0] ADDR_DT_HIGH = 7'h68;
	localparam int CMD_WRITE_BIT = 7;

	// mode register field positions
	localparam int MODE_GPIO_DIR = 7;
	localparam int MODE_GPIO_LEVEL = 6;
	localparam int MODE_CT_ROLL = 5;
	localparam int MODE_DT_ROLL = 4;
	localparam int MODE_THR_MSB = 3;
	localparam int MODE_THR_LSB = 1;
	localparam int MODE_POR = 0;

	// clear register field positions
	localparam int CLR_CT = 4;
	localparam int CLR_DT = 3;
	localparam int CLR_SELF = 2;
	localparam int CLR_CHG = 1;
	localparam int CLR_DIS = 0;
	localparam logic [7:0] CLR_USED_MASK = 8'h1F;

	// reset values
	localparam logic GPIO_DIR_RST = 1'b0;
	localparam logic GPIO_LEVEL_RST = 1'b1;
	localparam logic [2:0] THR_RST = 3'h7;
	localparam logic POR_FLAG_RST = 1'b1;
	localparam logic [7:0] CLEAR_RST = 8'h00;

	// timebase
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned SECONDS_PER_HOUR = 3600;
	localparam int unsigned FAST_COUNTS_PER_HOUR = 4096;
	localparam int unsigned SLOW_COUNTS_PER_HOUR = 16;
	localparam int unsigned SLOW_DIV = FAST_COUNTS_PER_HOUR /
		SLOW_COUNTS_PER_HOUR;
	localparam int unsigned FAST_TICK_CYCLES_DEF = int'(longint'(CLK_HZ) *
		longint'(SECONDS_PER_HOUR) / longint'(FAST_COUNTS_PER_HOUR));

	typedef enum logic [1:0] {
		P_CMD = 2'b01,
		P_DATA = 2'b10
	} ctm_parse_t;

	typedef enum logic [2:0] {
		S_RUN = 3'b001,
		S_PEND = 3'b010,
		S_SLEEP = 3'b100
	} ctm_sleep_t;
endpackage

//--- core/ctm_time_counter.sv
`timescale 1ns/1ps
module ctm_time_counter #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned SLOW_RATIO = ctm_pkg::SLOW_DIV
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic fast_tick,
	input wire logic active,
	input wire logic clear,
	output logic [WIDTH-1:0] count,
	output logic rollover
);
	import ctm_pkg::*;
	localparam int unsigned PW = $clog2(SLOW_RATIO);

	// the slow prescaler wraps by itself, so the ratio must be a power of two
	initial begin
		if (WIDTH < 2 || SLOW_RATIO < 2 || (1 << PW) != SLOW_RATIO)
			$error("ctm_time_counter: unsupported WIDTH or SLOW_RATIO");
	end

	logic [WIDTH-1:0] count_q;
	logic flag_q;
	logic [PW-1:0] presc_q;

	// slow mode steps once per SLOW_RATIO fast ticks
	wire step_en = fast_tick & active;
	wire slow_due = presc_q == PW'(SLOW_RATIO - 1);
	wire bump = step_en & (~flag_q | slow_due);
	wire wrap = bump & (count_q == '1);

	// clear beats any step in the same cycle
	always_ff @(posedge clk) begin
		if (!resetn || clear) begin
			count_q <= '0;
			flag_q <= 1'b0;
			presc_q <= '0;
		end else begin
			if (step_en & flag_q)
				presc_q <= presc_q + 1'b1;
			if (wrap)
				presc_q <= '0;
			if (bump)
				count_q <= count_q + 1'b1;
			if (wrap)
				flag_q <= ~flag_q;
		end
	end

	assign count = count_q;
	assign rollover = flag_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_fast_step;
		step_en && !flag_q && !clear |=> count_q == $past(count_q) + 1'b1;
	endproperty
	a_fast_step: assert property (p_fast_step)
		else $error("fast step missed");

	property p_wrap_set;
		wrap && !flag_q && !clear |=> flag_q && count_q == '0;
	endproperty
	a_wrap_set: assert property (p_wrap_set)
		else $error("rollover flag not set on wrap");

	property p_slow_hold;
		step_en && flag_q && !slow_due && !clear |=> $stable(count_q);
	endproperty
	a_slow_hold: assert property (p_slow_hold)
		else $error("count stepped early in slow mode");

	property p_wrap_clr;
		wrap && flag_q && !clear |=> !flag_q;
	endproperty
	a_wrap_clr: assert property (p_wrap_clr)
		else $error("second rollover left flag set");

	c_rollover: cover property (wrap && !flag_q);
endmodule

//--- core/ctm_regs.sv
// Behaviour
// - charge-time count high 0x66, low 0x65
// - charging steps count at fast rate
// - count wrap sets charge-time rollover flag
// - flagged counter steps at slow rate
// - second wrap clears the rollover flag
// - mode bit 7 selects gpio direction
// - mode bit 6 drives open-drain level
// - mode bits 5,4 show rollover flags
// - bits 3..1 gate sleep after power-down
// - threshold resets to ones; zero sleeps immediately
// - bit 0 set on brown-out, host-writable
// - clear bit 4 zeroes charge-time, self-clears
// - clear bit 3 zeroes discharge-time, self-clears
// - clear bit 2 zeroes self-discharge, self-clears
// - clear bit 1 zeroes charge count
// - clear bit 0 zeroes discharge count
// - discharge-time count at 0x68/0x67, same behaviour
// - command byte lsb first, bit7 write
`timescale 1ns/1ps
module ctm_regs #(
	parameter int unsigned FAST_TICK_CYCLES = ctm_pkg::FAST_TICK_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	input wire logic rx_restart,
	input wire logic charging,
	input wire logic discharging,
	input wire logic por_event,
	input wire logic power_down_cmd,
	input wire logic wake_event,
	input wire logic [2:0] sense_level,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic gpio_out,
	output logic gpio_oe,
	output logic sleep,
	output logic clr_self_discharge,
	output logic clr_charge_count,
	output logic clr_discharge_count
);
	import ctm_pkg::*;

	initial begin
		if (FAST_TICK_CYCLES < 1)
			$error("ctm_regs: FAST_TICK_CYCLES must be at least one");
	end

	ctm_parse_t parse_q;
	ctm_sleep_t sleep_st_q;
	logic [7:0] shift_q;
	logic [2:0] bit_cnt_q;
	logic [6:0] addr_q;
	logic rd_valid_q;
	logic [7:0] rd_data_q;
	logic [31:0] div_q;
	logic fast_tick_q;
	logic gpio_dir_q;
	logic gpio_level_q;
	logic gpio_oe_q;
	logic [2:0] thr_q;
	logic por_q;
	logic [7:0] clear_q;
	logic [15:0] ct_count;
	logic [15:0] dt_count;
	logic ct_roll;
	logic dt_roll;

	// serial assembly: bits arrive lsb first, so each shifts in at the top
	wire [7:0] shift_next = {rx_bit, shift_q[7:1]};
	wire byte_done = rx_bit_valid & (bit_cnt_q == 3'h7);
	wire [6:0] cmd_addr = shift_next[6:0];
	wire cmd_is_write = shift_next[CMD_WRITE_BIT];
	wire in_cmd = parse_q == P_CMD;
	wire in_data = parse_q == P_DATA;
	wire write_fire = byte_done & in_data;
	wire read_fire = byte_done & in_cmd & ~cmd_is_write;

	// write strobes per register, data is the byte just completed
	wire wr_clear = write_fire & (addr_q == ADDR_CLEAR);
	wire wr_mode = write_fire & (addr_q == ADDR_MODE);
	wire [7:0] wr_data = shift_next;

	// read selection; addresses outside this bank get no answer here
	wire hit_clear = cmd_addr == ADDR_CLEAR;
	wire hit_mode = cmd_addr == ADDR_MODE;
	wire hit_ct_lo = cmd_addr == ADDR_CT_LOW;
	wire hit_ct_hi = cmd_addr == ADDR_CT_HIGH;
	wire hit_dt_lo = cmd_addr == ADDR_DT_LOW;
	wire hit_dt_hi = cmd_addr == ADDR_DT_HIGH;
	wire addr_hit = hit_clear | hit_mode | hit_ct_lo | hit_ct_hi |
		hit_dt_lo | hit_dt_hi;
	wire [7:0] mode_view = {gpio_dir_q, gpio_level_q, ct_roll, dt_roll,
		thr_q, por_q};
	wire [7:0] rd_mux = hit_clear ? (clear_q & CLR_USED_MASK) :
		hit_mode ? mode_view :
		hit_ct_lo ? ct_count[7:0] :
		hit_ct_hi ? ct_count[15:8] :
		hit_dt_lo ? dt_count[7:0] :
		dt_count[15:8];

	// sleep is allowed only below the selected threshold; zero means always
	wire sleep_ok = (thr_q == 3'h0) | (sense_level < thr_q);

	// command parser: a restart pulse drops any half-received byte
	always_ff @(posedge clk) begin
		if (!resetn || rx_restart) begin
			parse_q <= P_CMD;
			shift_q <= 8'h00;
			bit_cnt_q <= 3'h0;
			addr_q <= 7'h00;
		end else if (rx_bit_valid) begin
			shift_q <= shift_next;
			bit_cnt_q <= bit_cnt_q + 3'h1;
			if (byte_done && in_cmd && cmd_is_write) begin
				addr_q <= cmd_addr;
				parse_q <= P_DATA;
			end else if (byte_done) begin
				parse_q <= P_CMD;
			end
		end
	end

	// read answer: one-cycle strobe with the byte, sampled at command end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= 8'h00;
		end else begin
			rd_valid_q <= read_fire & addr_hit;
			if (read_fire && addr_hit)
				rd_data_q <= rd_mux;
		end
	end

	// fast timebase; the slow rate is derived inside each counter so both
	// rates stay phase-locked to one divider
	always_ff @(posedge clk) begin
		if (!resetn) begin
			div_q <= 32'h0000_0000;
			fast_tick_q <= 1'b0;
		end else if (div_q == 32'(FAST_TICK_CYCLES - 1)) begin
			div_q <= 32'h0000_0000;
			fast_tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 32'h0000_0001;
			fast_tick_q <= 1'b0;
		end
	end

	// mode register; the rollover flags live in the counters and a host
	// write to them is ignored so a rollover cannot be hidden by mistake
	always_ff @(posedge clk) begin
		if (!resetn) begin
			gpio_dir_q <= GPIO_DIR_RST;
			gpio_level_q <= GPIO_LEVEL_RST;
			thr_q <= THR_RST;
			por_q <= POR_FLAG_RST;
		end else begin
			if (wr_mode) begin
				gpio_dir_q <= wr_data[MODE_GPIO_DIR];
				gpio_level_q <= wr_data[MODE_GPIO_LEVEL];
				thr_q <= wr_data[MODE_THR_MSB:MODE_THR_LSB];
				por_q <= wr_data[MODE_POR];
			end
			if (por_event)
				por_q <= 1'b1;
		end
	end

	// open-drain: enable only when configured as output and driving low
	always_ff @(posedge clk) begin
		if (!resetn) begin
			gpio_oe_q <= 1'b0;
		end else begin
			gpio_oe_q <= ~gpio_dir_q & ~gpio_level_q;
		end
	end

	// clear bits stand for exactly one cycle; the counters and the outside
	// counters act on that cycle, so the bits read back as zero afterwards
	always_ff @(posedge clk) begin
		if (!resetn) begin
			clear_q <= CLEAR_RST;
		end else if (wr_clear) begin
			clear_q <= wr_data & CLR_USED_MASK;
		end else begin
			clear_q <= 8'h00;
		end
	end

	// sleep sequencer: the power-down request waits for a quiet sense input
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sleep_st_q <= S_RUN;
		end else begin
			case (sleep_st_q)
			S_RUN: begin
				if (power_down_cmd)
					sleep_st_q <= S_PEND;
			end
			S_PEND: begin
				if (sleep_ok)
					sleep_st_q <= S_SLEEP;
			end
			S_SLEEP: begin
				if (wake_event)
					sleep_st_q <= S_RUN;
			end
			default: begin
				sleep_st_q <= S_RUN;
			end
			endcase
		end
	end

	ctm_time_counter #(
		.WIDTH(16),
		.SLOW_RATIO(SLOW_DIV)
	) u_charge_time (
		.clk(clk),
		.resetn(resetn),
		.fast_tick(fast_tick_q),
		.active(charging),
		.clear(clear_q[CLR_CT]),
		.count(ct_count),
		.rollover(ct_roll)
	);

	ctm_time_counter #(
		.WIDTH(16),
		.SLOW_RATIO(SLOW_DIV)
	) u_discharge_time (
		.clk(clk),
		.resetn(resetn),
		.fast_tick(fast_tick_q),
		.active(discharging),
		.clear(clear_q[CLR_DT]),
		.count(dt_count),
		.rollover(dt_roll)
	);

	// every output except the constant gpio_out is a flop or a single flop bit
	assign rd_valid = rd_valid_q;
	assign rd_data = rd_data_q;
	assign gpio_out = 1'b0; // open-drain only ever pulls low
	assign gpio_oe = gpio_oe_q;
	assign sleep = sleep_st_q[2];
	assign clr_self_discharge = clear_q[CLR_SELF];
	assign clr_charge_count = clear_q[CLR_CHG];
	assign clr_discharge_count = clear_q[CLR_DIS];

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_read_ct_high;
		read_fire && hit_ct_hi |=>
			rd_valid && rd_data == $past(ct_count[15:8]);
	endproperty
	a_read_ct_high: assert property (p_read_ct_high)
		else $error("charge-time high byte read wrong");

	property p_gpio_drive;
		!gpio_dir_q && !gpio_level_q && !wr_mode |=> ##1 gpio_oe;
	endproperty
	a_gpio_drive: assert property (p_gpio_drive)
		else $error("gpio not driven low");

	property p_gpio_input;
		gpio_dir_q |=> !gpio_oe;
	endproperty
	a_gpio_input: assert property (p_gpio_input)
		else $error("gpio driven while input");

	property p_mode_flags;
		read_fire && hit_mode |=> rd_data[MODE_CT_ROLL] == $past(ct_roll)
			&& rd_data[MODE_DT_ROLL] == $past(dt_roll);
	endproperty
	a_mode_flags: assert property (p_mode_flags)
		else $error("mode read lost rollover flags");

	property p_sleep_gate;
		sleep_st_q == S_PEND && !sleep_ok |=> !sleep;
	endproperty
	a_sleep_gate: assert property (p_sleep_gate)
		else $error("slept above threshold");

	property p_zero_thr;
		sleep_st_q == S_RUN && power_down_cmd && thr_q == 3'h0 && !wr_mode
			|=> ##1 sleep;
	endproperty
	a_zero_thr: assert property (p_zero_thr)
		else $error("zero threshold did not sleep at once");

	property p_por_set;
		por_event |=> por_q;
	endproperty
	a_por_set: assert property (p_por_set)
		else $error("brown-out flag lost");

	property p_ct_clear;
		wr_clear && wr_data[CLR_CT] |=> clear_q[CLR_CT]
			##1 !clear_q[CLR_CT] && ct_count == 16'h0000 && !ct_roll;
	endproperty
	a_ct_clear: assert property (p_ct_clear)
		else $error("charge-time clear failed");

	property p_chg_clear;
		wr_clear && wr_data[CLR_CHG] |=> clr_charge_count ##1
			!clr_charge_count;
	endproperty
	a_chg_clear: assert property (p_chg_clear)
		else $error("charge count clear pulse wrong");

	// discharge-time clear also drops its rollover flag
	property p_dt_clear;
		wr_clear && wr_data[CLR_DT] |=> clear_q[CLR_DT]
			##1 dt_count == 16'h0000 && !dt_roll;
	endproperty
	a_dt_clear: assert property (p_dt_clear)
		else $error("discharge-time clear failed");

	property p_sd_clear;
		wr_clear && wr_data[CLR_SELF] |=> clr_self_discharge ##1
			!clr_self_discharge;
	endproperty
	a_sd_clear: assert property (p_sd_clear)
		else $error("self-discharge clear pulse wrong");

	property p_dis_clear;
		wr_clear && wr_data[CLR_DIS] |=> clr_discharge_count ##1
			!clr_discharge_count;
	endproperty
	a_dis_clear: assert property (p_dis_clear)
		else $error("discharge count clear pulse wrong");

	// the host may set or clear the power-on flag; an event still wins
	property p_por_write;
		wr_mode && !por_event |=> por_q == $past(wr_data[MODE_POR]);
	endproperty
	a_por_write: assert property (p_por_write)
		else $error("host write of power-on flag lost");

	property p_clear_first;
		(clear_q != 8'h00) |-> !byte_done;
	endproperty
	a_clear_first: assert property (p_clear_first)
		else $error("access accepted before clear landed");

	c_sleep: cover property (sleep_st_q == S_PEND ##1 sleep);
	c_clear: cover property (wr_clear && wr_data[CLR_CT]);
	c_read: cover property (read_fire && hit_dt_hi);
endmodule

//--- testbench/ctm_host.sv
`timescale 1ns/1ps
// host end of the register link: shifts command and data bytes in
module ctm_host (
	input wire logic clk,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	output logic rx_bit_valid,
	output logic rx_bit,
	output logic rx_restart
);
	import ctm_pkg::*;
	logic slow;
	// idle line shows the inverse of the last bit, never a stale copy
	initial begin
		rx_bit_valid = 1'b0;
		rx_bit = 1'b1;
		rx_restart = 1'b0;
		slow = 1'b0;
	end
	// slow mode idles one cycle between bits, never after the last one
	task automatic send_bits(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			rx_bit_valid <= 1'b1;
			rx_bit <= b[i];
			if (slow && i < n - 1) begin
				@(posedge clk);
				rx_bit_valid <= 1'b0;
				rx_bit <= ~b[i];
			end
		end
		@(posedge clk);
		rx_bit_valid <= 1'b0;
		rx_bit <= ~b[n-1];
	endtask
	task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
		send_bits({1'b1, a}, 8);
		// reserved clear bits always go out as zero
		send_bits((a == ADDR_CLEAR) ? (d & CLR_USED_MASK) : d, 8);
	endtask
	// answer edge counted from the edge that takes the eighth bit
	task automatic read_reg(input logic [6:0] a, output logic [7:0] d,
		output int lat);
		send_bits({1'b0, a}, 8);
		d = 8'h00;
		lat = 0;
		// look just after each edge, so the one-cycle strobe is not missed
		for (int n = 1; n <= 3; n++) begin
			#1;
			if (rd_valid === 1'b1 && lat == 0) begin
				lat = n;
				d = rd_data;
			end
			@(posedge clk);
		end
	endtask
	// stray partial byte, then restart so the parser drops it
	task automatic abort_byte();
		send_bits(8'h05, 3);
		rx_restart <= 1'b1;
		@(posedge clk);
		rx_restart <= 1'b0;
	endtask
endmodule

//--- testbench/ctm_regs_tb.sv
`timescale 1ns/1ps
module ctm_regs_tb;
	import ctm_pkg::*;
	logic clk, resetn, charging, discharging, por_event, power_down_cmd;
	logic wake_event, rx_bit_valid, rx_bit, rx_restart, rd_valid;
	logic gpio_out, gpio_oe, sleep, clr_sd, clr_cc, clr_dc;
	logic [2:0] sense_level;
	logic [7:0] rd_data, d, w;
	logic [15:0] v;
	int bad_count = 0;
	int cmp_count = 0;
	int seed = 25;
	int cyc = 0;
	int lat;
	int pulses [3] = '{0, 0, 0};

	// one tick per clock so a full wrap fits in the run
	ctm_regs #(.FAST_TICK_CYCLES(1)) DUT (
		.clk(clk), .resetn(resetn), .rx_bit_valid(rx_bit_valid),
		.rx_bit(rx_bit), .rx_restart(rx_restart), .charging(charging),
		.discharging(discharging), .por_event(por_event),
		.power_down_cmd(power_down_cmd), .wake_event(wake_event),
		.sense_level(sense_level), .rd_valid(rd_valid), .rd_data(rd_data),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .sleep(sleep),
		.clr_self_discharge(clr_sd), .clr_charge_count(clr_cc),
		.clr_discharge_count(clr_dc)
	);
	ctm_host host (
		.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
		.rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
		.rx_restart(rx_restart)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// cut a hang short well past the expected run length
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 90000) begin
			bad_count++;
			test_done();
		end
	end
	// count the one-cycle clear strobes
	always @(posedge clk) begin
		pulses[0] += int'(clr_dc);
		pulses[1] += int'(clr_cc);
		pulses[2] += int'(clr_sd);
	end

	task automatic check_eq(input string n, input logic [7:0] e, g);
		cmp_count++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask
	// counts are checked against a window since the tick phase is free
	task automatic check_rng(input string n, input logic [15:0] lo, hi, g);
		cmp_count++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			$display("unexpected %s expected %h..%h seen %h", n, lo, hi, g);
			bad_count++;
		end
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] dv);
		int l;
		host.read_reg(a, dv, l);
		check_eq("read latency", 8'h01, 8'(l));
	endtask
	task automatic rd16(input logic [6:0] a, output logic [15:0] r);
		rd(a, r[7:0]);
		rd(a + 7'h01, r[15:8]);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(input int k);
		@(posedge clk);
		if (k == 0) power_down_cmd <= 1'b1;
		else wake_event <= 1'b1;
		@(posedge clk);
		power_down_cmd <= 1'b0;
		wake_event <= 1'b0;
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		resetn = 1'b0;
		charging = 1'b0;
		discharging = 1'b0;
		por_event = 1'b0;
		power_down_cmd = 1'b0;
		wake_event = 1'b0;
		sense_level = 3'h0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd(ADDR_MODE, d);
		check_eq("mode reset", 8'h4F, d);
		rd(ADDR_CLEAR, d);
		check_eq("clear reset", 8'h00, d);
		$display("reset test done");
		// corner values first, then random, alternating host pace
		for (int i = 0; i < 10; i++) begin
			w = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
			host.slow = i[0];
			@(posedge clk) sense_level <= 3'($random(seed));
			host.write_reg(ADDR_MODE, w);
			rd(ADDR_MODE, d);
			check_eq("mode", {w[7:6], 2'h0, w[3:0]}, d);
			check_eq("gpio_oe", {7'h00, ~(w[7] | w[6])}, {7'h00, gpio_oe});
			check_eq("gpio_out", 8'h00, {7'h00, gpio_out});
		end
		host.slow = 1'b0;
		host.write_reg(ADDR_MODE, 8'h4E);
		@(posedge clk) por_event <= 1'b1;
		@(posedge clk) por_event <= 1'b0;
		rd(ADDR_MODE, d);
		check_eq("mode por", 8'h4F, d);
		host.abort_byte();
		host.read_reg(7'h10, d, lat);
		check_eq("unmapped answer", 8'h00, 8'(lat));
		$display("mode test done");
		host.write_reg(ADDR_MODE, 8'h40);
		pulse(0);
		wait_cyc(2);
		check_eq("sleep thr zero", 8'h01, 8'(sleep));
		pulse(1);
		wait_cyc(2);
		host.write_reg(ADDR_MODE, 8'h46);
		@(posedge clk) sense_level <= 3'h5;
		pulse(0);
		wait_cyc(4);
		check_eq("sleep above thr", 8'h00, 8'(sleep));
		@(posedge clk) sense_level <= 3'h2;
		wait_cyc(2);
		check_eq("sleep below thr", 8'h01, 8'(sleep));
		pulse(1);
		wait_cyc(2);
		$display("sleep test done");
		for (int k = 0; k < 3; k++) host.write_reg(ADDR_CLEAR, 8'hE1 << k);
		wait_cyc(2);
		for (int k = 0; k < 3; k++)
			check_eq("clear strobe", 8'h01, 8'(pulses[k]));
		rd(ADDR_CLEAR, d);
		check_eq("clear self", 8'h00, d);
		@(posedge clk) charging <= 1'b1;
		wait_cyc(1000);
		@(posedge clk) charging <= 1'b0;
		rd16(ADDR_CT_LOW, v);
		check_rng("charge time", 16'h03E3, 16'h03EA, v);
		@(posedge clk) discharging <= 1'b1;
		wait_cyc(200);
		@(posedge clk) discharging <= 1'b0;
		rd16(ADDR_DT_LOW, v);
		check_rng("discharge time", 16'h00C3, 16'h00CA, v);
		host.write_reg(ADDR_CLEAR, 8'h08);
		rd16(ADDR_DT_LOW, v);
		check_rng("discharge cleared", 16'h0000, 16'h0000, v);
		$display("count test done");
		// run the charge-time count through its wrap
		rd16(ADDR_CT_LOW, v);
		@(posedge clk) charging <= 1'b1;
		wait_cyc(65536 - int'(v) + 20);
		@(posedge clk) charging <= 1'b0;
		rd(ADDR_MODE, d);
		check_eq("rollover flag", 8'h20, d & 8'h30);
		rd16(ADDR_CT_LOW, v);
		check_rng("after wrap", 16'h0000, 16'h0001, v);
		@(posedge clk) charging <= 1'b1;
		wait_cyc(600);
		@(posedge clk) charging <= 1'b0;
		rd16(ADDR_CT_LOW, v);
		check_rng("slow rate", 16'h0001, 16'h0003, v);
		host.write_reg(ADDR_CLEAR, 8'h10);
		rd16(ADDR_CT_LOW, v);
		check_rng("charge cleared", 16'h0000, 16'h0000, v);
		rd(ADDR_MODE, d);
		check_eq("flag cleared", 8'h00, d & 8'h20);
		@(posedge clk) charging <= 1'b1;
		wait_cyc(100);
		@(posedge clk) charging <= 1'b0;
		rd16(ADDR_CT_LOW, v);
		check_rng("fast again", 16'h005F, 16'h0066, v);
		$display("rollover test done");
		test_done();
	end
endmodule
